// [rtl/pdemx_mux.sv]
module pdemx_mux #(
  parameter int unsigned PORT_W = pdemx_pkg::PORT_W
) (
  input  wire logic       mclk,
  input  wire logic       rst_b,
  // Port D controls and pad
  input  wire logic [7:0] pd_latch,
  input  wire logic [7:0] pd_direction,
  input  wire logic [7:0] pd_pin_in,
  input  wire logic       pullup_disable,
  input  wire logic       lcd_drive_on,
  input  wire logic       lcd_port_mask,
  input  wire logic       irq_zero_enable,
  input  wire logic [7:0] lcd_segment_signal,
  // Port E controls and pad
  input  wire logic [7:0] pe_latch,
  input  wire logic [7:0] pe_direction,
  input  wire logic [7:0] pe_pin_in,
  input  wire logic       clock_out_fuse,
  input  wire logic       divided_clock,
  input  wire logic       usi_three_wire,
  input  wire logic       universal_serial_out,
  input  wire logic       usart_sync_mode,
  input  wire logic       usart_clock_out,
  input  wire logic       usart_tx_enable,
  input  wire logic       usart_transmit_line,
  // Pad drive
  output logic [7:0]      pd_out,
  output logic [7:0]      pd_oe,
  output logic [7:0]      pd_pullup,
  output logic [7:0]      pd_input_en,
  output logic [7:0]      front_plane_drive,
  output logic [7:0]      pe_out,
  output logic [7:0]      pe_oe,
  output logic [7:0]      pe_pullup,
  // Peripheral side
  output logic            external_irq_zero,
  output logic            capture_input_one,
  output logic [7:0]      pin_change_irq_source,
  output logic            universal_serial_in,
  output logic            two_wire_data_in,
  output logic            universal_serial_clock,
  output logic            two_wire_clock_in,
  output logic            usart_external_clock,
  output logic            comparator_plus_input,
  output logic            comparator_minus_input
);
  logic       lcd_mask;
  logic [7:0] pu_oe, dd_oe, di_oe, di_ov;
  logic [7:0] pd_out_nxt, pd_oe_nxt, pd_pu_nxt, pd_ie_nxt;
  logic [7:0] pe_out_nxt, pe_oe_nxt;

  assign lcd_mask = lcd_drive_on & lcd_port_mask;

  // Bit positions are fixed to the eight-bit ports
  generate
    if (PORT_W != pdemx_pkg::PORT_W) begin : g_width_check
      $error("pdemx_mux serves only the eight-bit ports");
    end
  endgenerate

  genvar i;
  generate
    for (i = 0; i < PORT_W; i++) begin : g_pd
      if (i == pdemx_pkg::PD_IRQ_BIT) begin : g_irq
        assign di_oe[i] = lcd_drive_on | irq_zero_enable;
        assign di_ov[i] = lcd_drive_on & irq_zero_enable;
      end else begin : g_seg
        assign di_oe[i] = lcd_mask;
        assign di_ov[i] = 1'b0;
      end
      assign pu_oe[i] = lcd_mask;
      assign dd_oe[i] = lcd_mask;
    end
  endgenerate

  always_comb begin
    pd_out_nxt = pd_latch;
    pd_oe_nxt  = (pd_direction & ~dd_oe);
    pd_pu_nxt  = pd_latch & ~pd_direction & ~pu_oe & {8{~pullup_disable}};
    pd_ie_nxt  = (di_oe & di_ov) | (~di_oe);
  end

  always_comb begin
    pe_out_nxt = pe_latch;
    pe_oe_nxt  = pe_direction;
    if (usi_three_wire) begin
      pe_out_nxt[pdemx_pkg::PE_DO_BIT] = universal_serial_out;
    end
    if (usart_sync_mode && pe_direction[pdemx_pkg::PE_XCK_BIT]) begin
      pe_out_nxt[pdemx_pkg::PE_XCK_BIT] = usart_clock_out;
    end
    if (usart_tx_enable) begin
      pe_out_nxt[pdemx_pkg::PE_TX_BIT] = usart_transmit_line;
      pe_oe_nxt[pdemx_pkg::PE_TX_BIT]  = 1'b1;
    end
    if (clock_out_fuse) begin
      pe_out_nxt[pdemx_pkg::PE_CLK_BIT] = divided_clock;
      pe_oe_nxt[pdemx_pkg::PE_CLK_BIT]  = 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      pd_out      <= pdemx_pkg::BYTE_ZERO;
      pd_oe       <= pdemx_pkg::BYTE_ZERO;
      pd_pullup   <= pdemx_pkg::BYTE_ZERO;
      pd_input_en <= pdemx_pkg::BYTE_ZERO;
    end else begin
      pd_out      <= pd_out_nxt;
      pd_oe       <= pd_oe_nxt;
      pd_pullup   <= pd_pu_nxt;
      pd_input_en <= pd_ie_nxt;
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      front_plane_drive <= pdemx_pkg::BYTE_ZERO;
    end else begin
      front_plane_drive <= lcd_segment_signal & {8{lcd_mask}};
    end
  end

  // Port E pads keep running through reset for the clock pin
  always_ff @(posedge mclk) begin
    pe_out    <= rst_b ? pe_out_nxt
               : {clock_out_fuse & divided_clock,
                  {pdemx_pkg::PE_CLK_BIT{1'b0}}};
    pe_oe     <= rst_b ? pe_oe_nxt
               : {clock_out_fuse, {pdemx_pkg::PE_CLK_BIT{1'b0}}};
    pe_pullup <= rst_b ? (pe_latch & ~pe_oe_nxt & {8{~pullup_disable}})
               : pdemx_pkg::BYTE_ZERO;
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      external_irq_zero      <= 1'b0;
      capture_input_one      <= 1'b0;
      pin_change_irq_source  <= pdemx_pkg::BYTE_ZERO;
      universal_serial_in    <= 1'b0;
      two_wire_data_in       <= 1'b0;
      universal_serial_clock <= 1'b0;
      two_wire_clock_in      <= 1'b0;
      usart_external_clock   <= 1'b0;
      comparator_plus_input  <= 1'b0;
      comparator_minus_input <= 1'b0;
    end else begin
      external_irq_zero      <= pd_pin_in[pdemx_pkg::PD_IRQ_BIT];
      capture_input_one      <= pd_pin_in[pdemx_pkg::PD_CAP_BIT];
      pin_change_irq_source  <= pe_pin_in;
      universal_serial_in    <= pe_pin_in[pdemx_pkg::PE_SDA_BIT];
      two_wire_data_in       <= pe_pin_in[pdemx_pkg::PE_SDA_BIT];
      universal_serial_clock <= pe_pin_in[pdemx_pkg::PE_SCL_BIT];
      two_wire_clock_in      <= pe_pin_in[pdemx_pkg::PE_SCL_BIT];
      usart_external_clock   <= usart_sync_mode
                              & pe_pin_in[pdemx_pkg::PE_XCK_BIT];
      comparator_plus_input  <= pe_pin_in[pdemx_pkg::PE_XCK_BIT];
      comparator_minus_input <= pe_pin_in[pdemx_pkg::PE_AMI_BIT];
    end
  end

  a_lcd_dir_off: assert property (
    @(posedge mclk) disable iff (!rst_b)
    lcd_mask |=> (pd_oe == pdemx_pkg::BYTE_ZERO))
    else $error("lcd overridden pin driven");

  a_lcd_ie_off: assert property (
    @(posedge mclk) disable iff (!rst_b)
    lcd_mask |=>
      ((pd_input_en & pdemx_pkg::PD_SEG_ONLY) == pdemx_pkg::BYTE_ZERO))
    else $error("lcd overridden input enabled");

  a_lcd_pull_off: assert property (
    @(posedge mclk) disable iff (!rst_b)
    lcd_mask |=> (pd_pullup == pdemx_pkg::BYTE_ZERO))
    else $error("lcd overridden pin pulled");

  a_lcd_out_plain: assert property (
    @(posedge mclk) disable iff (!rst_b)
    1'b1 |=> pd_out == $past(pd_latch))
    else $error("port d value overridden");

  a_irq_input_on: assert property (
    @(posedge mclk) disable iff (!rst_b)
    (lcd_drive_on && irq_zero_enable) |=>
      pd_input_en[pdemx_pkg::PD_IRQ_BIT])
    else $error("irq input disabled");

  a_irq_input_off: assert property (
    @(posedge mclk) disable iff (!rst_b)
    (lcd_drive_on && !irq_zero_enable) |=>
      !pd_input_en[pdemx_pkg::PD_IRQ_BIT])
    else $error("irq input not cut");

  a_irq_follow: assert property (
    @(posedge mclk) disable iff (!rst_b)
    1'b1 |=> external_irq_zero == $past(pd_pin_in[pdemx_pkg::PD_IRQ_BIT]))
    else $error("irq source wrong");

  a_cap_follow: assert property (
    @(posedge mclk) disable iff (!rst_b)
    1'b1 |=> capture_input_one == $past(pd_pin_in[pdemx_pkg::PD_CAP_BIT]))
    else $error("capture input wrong");

  a_seg_link: assert property (
    @(posedge mclk) disable iff (!rst_b)
    lcd_mask |=> front_plane_drive == $past(lcd_segment_signal))
    else $error("segment not linked");

  a_pcint_follow: assert property (
    @(posedge mclk) disable iff (!rst_b)
    1'b1 |=> pin_change_irq_source == $past(pe_pin_in))
    else $error("pin change source wrong");

  a_clk_forced: assert property (
    @(posedge mclk)
    clock_out_fuse |=> pe_oe[pdemx_pkg::PE_CLK_BIT]
      && pe_out[pdemx_pkg::PE_CLK_BIT] == $past(divided_clock))
    else $error("divided clock not driven");

  a_clk_no_pull: assert property (
    @(posedge mclk) disable iff (!rst_b)
    clock_out_fuse |=> !pe_pullup[pdemx_pkg::PE_CLK_BIT])
    else $error("divided clock pin pulled");

  a_clk_in_reset: assert property (
    @(posedge mclk)
    !rst_b |=> pe_oe[pdemx_pkg::PE_CLK_BIT] == $past(clock_out_fuse))
    else $error("divided clock lost in reset");

  a_usi_out: assert property (
    @(posedge mclk) disable iff (!rst_b)
    usi_three_wire |=>
      pe_out[pdemx_pkg::PE_DO_BIT] == $past(universal_serial_out))
    else $error("serial out not driven");

  a_usi_in: assert property (
    @(posedge mclk) disable iff (!rst_b)
    1'b1 |=> universal_serial_in == $past(pe_pin_in[pdemx_pkg::PE_SDA_BIT]))
    else $error("serial in wrong");

  a_sda_in: assert property (
    @(posedge mclk) disable iff (!rst_b)
    1'b1 |=> two_wire_data_in == $past(pe_pin_in[pdemx_pkg::PE_SDA_BIT]))
    else $error("two-wire data wrong");

  a_universal_serial_clock_in: assert property (
    @(posedge mclk) disable iff (!rst_b)
    1'b1 |=>
      universal_serial_clock == $past(pe_pin_in[pdemx_pkg::PE_SCL_BIT]))
    else $error("serial clock wrong");

  a_scl_in: assert property (
    @(posedge mclk) disable iff (!rst_b)
    1'b1 |=> two_wire_clock_in == $past(pe_pin_in[pdemx_pkg::PE_SCL_BIT]))
    else $error("two-wire clock wrong");

  a_xck_out: assert property (
    @(posedge mclk) disable iff (!rst_b)
    (usart_sync_mode && pe_direction[pdemx_pkg::PE_XCK_BIT]) |=>
      pe_out[pdemx_pkg::PE_XCK_BIT] == $past(usart_clock_out))
    else $error("usart clock not driven");

  a_xck_idle: assert property (
    @(posedge mclk) disable iff (!rst_b)
    !usart_sync_mode |=> !usart_external_clock)
    else $error("usart clock active out of sync mode");

  a_cmp_plus: assert property (
    @(posedge mclk) disable iff (!rst_b)
    1'b1 |=>
      comparator_plus_input == $past(pe_pin_in[pdemx_pkg::PE_XCK_BIT]))
    else $error("comparator plus wrong");

  a_cmp_minus: assert property (
    @(posedge mclk) disable iff (!rst_b)
    1'b1 |=>
      comparator_minus_input == $past(pe_pin_in[pdemx_pkg::PE_AMI_BIT]))
    else $error("comparator minus wrong");

  a_tx_drive: assert property (
    @(posedge mclk) disable iff (!rst_b)
    usart_tx_enable |=> pe_oe[pdemx_pkg::PE_TX_BIT]
      && pe_out[pdemx_pkg::PE_TX_BIT] == $past(usart_transmit_line))
    else $error("transmit not driven");

  a_port_plain: assert property (
    @(posedge mclk) disable iff (!rst_b)
    !lcd_mask |=> pd_oe == $past(pd_direction) && pd_out == $past(pd_latch))
    else $error("plain port not followed");

  a_pull_plain: assert property (
    @(posedge mclk) disable iff (!rst_b)
    !lcd_mask |=> pd_pullup ==
      $past(pd_latch & ~pd_direction & {8{~pullup_disable}}))
    else $error("plain pull-up not followed");

  a_pe_plain: assert property (
    @(posedge mclk) disable iff (!rst_b)
    (!usart_tx_enable && !clock_out_fuse && !usi_three_wire
      && !usart_sync_mode) |=>
      pe_oe == $past(pe_direction) && pe_out == $past(pe_latch))
    else $error("plain port e not followed");

  // Main scenarios
  c_lcd_on: cover property (@(posedge mclk) lcd_mask);
  c_clk_reset: cover property (@(posedge mclk) !rst_b && clock_out_fuse);
  c_three_wire: cover property (@(posedge mclk) rst_b && usi_three_wire);
  c_tx_on: cover property (@(posedge mclk) rst_b && usart_tx_enable);
  c_xck_out: cover property (@(posedge mclk)
    rst_b && usart_sync_mode && pe_direction[pdemx_pkg::PE_XCK_BIT]);
endmodule

// [rtl/pdemx_pkg.sv]
// What this block does
// - Bits D7 to D4 take LCD masked pull-up, direction, input overrides.
// - Bits D3, D2 and D0 take the masked overrides with no value override.
// - Bit D1 feeds external_irq_zero with its own input override terms.
// - Bit D0 delivers its input as capture_input_one to timer one.
// - Bits D7 to D0 link their analog path to the LCD front-plane segments.
// - Every Port E pin gives its input as its own pin-change source.
// - A set clock_out_fuse drives the divided clock out on bit E7.
// - A set clock_out_fuse keeps the divided clock on bit E7 through reset.
// - Bit E6 carries universal_serial_out in three-wire mode.
// - Bit E5 is universal_serial_in and the two-wire data line.
// - Bit E4 is universal_serial_clock and the two-wire clock line.
// - Bit E2 carries the USART clock only in synchronous mode.
// - Bits E3 and E2 link straight to the comparator minus and plus inputs.
// - Bit E1 carries usart_transmit_line.
package pdemx_pkg;
  localparam int unsigned PORT_W     = 8;
  localparam int unsigned PD_IRQ_BIT = 1;
  localparam int unsigned PD_CAP_BIT = 0;
  localparam int unsigned PE_CLK_BIT = 7;
  localparam int unsigned PE_DO_BIT  = 6;
  localparam int unsigned PE_SDA_BIT = 5;
  localparam int unsigned PE_SCL_BIT = 4;
  localparam int unsigned PE_AMI_BIT = 3;
  localparam int unsigned PE_XCK_BIT = 2;
  localparam int unsigned PE_TX_BIT  = 1;
  localparam logic [7:0]  BYTE_ZERO  = 8'h00;
  localparam logic [7:0]  PD_SEG_ONLY = 8'hFD;
endpackage

// [testbench/pdemx_pads.sv]
module pdemx_pads (
  input  wire logic [7:0] pad_out,
  input  wire logic [7:0] pad_oe,
  input  wire logic [7:0] pad_pullup,
  input  wire logic [7:0] ext_level,
  output logic [7:0]      pin
);
  timeunit 1ns;
  timeprecision 1ps;
  // Driven pad wins, then pull-up, then the outside level
  assign pin = (pad_oe & pad_out) | (~pad_oe & (pad_pullup | ext_level));
endmodule

// [testbench/port_d_e_alt_function_mux_test.sv]
module port_d_e_alt_function_mux_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic       mclk = 0;
  logic       rst_b = 0;
  logic [7:0] pd_latch, pd_direction, pd_pin_in, lcd_segment_signal, ext_d;
  logic [7:0] pe_latch, pe_direction, pe_pin_in, ext_e, p_d, p_e, e_ie;
  logic       pullup_disable, lcd_drive_on, lcd_port_mask, irq_zero_enable;
  logic       clock_out_fuse, divided_clock, usi_three_wire, usart_sync_mode;
  logic       universal_serial_out, usart_clock_out, usart_tx_enable;
  logic       usart_transmit_line, external_irq_zero, capture_input_one;
  logic [7:0] pd_out, pd_oe, pd_pullup, pd_input_en, front_plane_drive;
  logic [7:0] pe_out, pe_oe, pe_pullup, pin_change_irq_source;
  logic       universal_serial_in, two_wire_data_in, universal_serial_clock;
  logic       two_wire_clock_in, usart_external_clock, comparator_plus_input;
  logic       comparator_minus_input, m;
  int         bad_count = 0;
  int         n_checks = 0;
  always #10 mclk = ~mclk;
  pdemx_mux u_pdemx_mux (.mclk, .rst_b, .pd_latch, .pd_direction, .pd_pin_in,
    .pullup_disable, .lcd_drive_on, .lcd_port_mask, .irq_zero_enable,
    .lcd_segment_signal, .pe_latch, .pe_direction, .pe_pin_in,
    .clock_out_fuse, .divided_clock, .usi_three_wire, .universal_serial_out,
    .usart_sync_mode, .usart_clock_out, .usart_tx_enable,
    .usart_transmit_line, .pd_out, .pd_oe, .pd_pullup, .pd_input_en,
    .front_plane_drive, .pe_out, .pe_oe, .pe_pullup, .external_irq_zero,
    .capture_input_one, .pin_change_irq_source, .universal_serial_in,
    .two_wire_data_in, .universal_serial_clock, .two_wire_clock_in,
    .usart_external_clock, .comparator_plus_input, .comparator_minus_input);
  pdemx_pads u_pdemx_pads_d (.pad_out(pd_out), .pad_oe(pd_oe),
    .pad_pullup(pd_pullup), .ext_level(ext_d), .pin(pd_pin_in));
  pdemx_pads u_pdemx_pads_e (.pad_out(pe_out), .pad_oe(pe_oe),
    .pad_pullup(pe_pullup), .ext_level(ext_e), .pin(pe_pin_in));
  task automatic chk(string what, logic [7:0] seen, logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic settle();
    repeat (2) @(posedge mclk);
    #1;
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    #20000;
    bad_count++;
    give_verdict();
  end
  initial begin
    {pd_latch, pd_direction, lcd_segment_signal, ext_d, ext_e} = '0;
    {pe_latch, pe_direction, pullup_disable, lcd_drive_on} = '0;
    {lcd_port_mask, irq_zero_enable, usi_three_wire, usart_sync_mode} = '0;
    {universal_serial_out, usart_clock_out, usart_tx_enable} = '0;
    usart_transmit_line = 0;
    clock_out_fuse = 1;
    divided_clock = 1;
    repeat (5) @(posedge mclk);
    #1;
    chk("reset pe_out", pe_out, 8'h80);
    chk("reset pe_oe", pe_oe, 8'h80);
    rst_b = 1;
    clock_out_fuse = 0;
    for (int k = 0; k < 4; k++) begin
      pd_latch = 8'hA5 ^ {8{k[0]}};
      pd_direction = 8'h0F << k;
      pe_latch = 8'h3C ^ 8'(k);
      pe_direction = 8'h81 >> k;
      pullup_disable = k[1];
      ext_d = 8'h69 << k;
      ext_e = 8'hC3 >> k;
      settle();
      p_d = pd_latch & ~pd_direction & ~{8{pullup_disable}};
      p_e = pe_latch & ~pe_direction & ~{8{pullup_disable}};
      chk("pd_pullup", pd_pullup, p_d);
      chk("pe_pullup", pe_pullup, p_e);
      p_d = (pd_direction & pd_latch) | (~pd_direction & (p_d | ext_d));
      p_e = (pe_direction & pe_latch) | (~pe_direction & (p_e | ext_e));
      chk("pd_oe", pd_oe, pd_direction);
      chk("pe_oe", pe_oe, pe_direction);
      chk("pe_out", pe_out, pe_latch);
      chk("pd_input_en", pd_input_en, 8'hFF);
      chk("front_plane", front_plane_drive, 8'h00);
      chk("pin change", pin_change_irq_source, p_e);
      chk("irq", external_irq_zero, p_d[1]);
      chk("capture", capture_input_one, p_d[0]);
      chk("serial in", {universal_serial_in, two_wire_data_in}, {2{p_e[5]}});
      chk("serial clk", {universal_serial_clock, two_wire_clock_in},
        {2{p_e[4]}});
      chk("comparator", {comparator_minus_input, comparator_plus_input},
        p_e[3:2]);
      chk("usart clk idle", usart_external_clock, 8'h00);
    end
    pd_latch = 8'hFF;
    pd_direction = 8'h55;
    pullup_disable = 0;
    for (int c = 0; c < 8; c++) begin
      {lcd_drive_on, lcd_port_mask, irq_zero_enable} = 3'(c);
      lcd_segment_signal = 8'h3C ^ 8'(c);
      settle();
      m = lcd_drive_on & lcd_port_mask;
      e_ie = m ? 8'h00 : 8'hFF;
      e_ie[1] = (lcd_drive_on | irq_zero_enable) ?
        (lcd_drive_on & irq_zero_enable) : 1'b1;
      chk("lcd pd_oe", pd_oe, m ? 8'h00 : pd_direction);
      chk("lcd pd_pullup", pd_pullup, m ? 8'h00 : 8'hAA);
      chk("lcd pd_input_en", pd_input_en, e_ie);
      chk("lcd pd_out", pd_out, pd_latch);
      chk("segments", front_plane_drive,
        m ? lcd_segment_signal : 8'h00);
    end
    {clock_out_fuse, usi_three_wire, usart_tx_enable} = 3'b111;
    pe_direction = 8'h04;
    ext_e = 8'h00;
    for (int v = 0; v < 2; v++) begin
      {usart_sync_mode, divided_clock, universal_serial_out} = {3{v[0]}};
      {usart_clock_out, usart_transmit_line} = {2{v[0]}};
      pe_latch = {8{~v[0]}};
      settle();
      chk("alt pe_oe", pe_oe, 8'h86);
      chk("alt pe_out", pe_out, v ? 8'hC6 : 8'h3D);
      chk("alt pe_pullup", pe_pullup, v ? 8'h00 : 8'h79);
      chk("usart clock", usart_external_clock, 8'(v));
    end
    rst_b = 0;
    settle();
    chk("mid reset pe_out", pe_out, 8'h80);
    chk("mid reset pe_oe", pe_oe, 8'h80);
    chk("mid reset pd_oe", pd_oe, 8'h00);
    rst_b = 1;
    settle();
    chk("after reset pe_oe", pe_oe, 8'h86);
    give_verdict();
  end
endmodule
